//--- verilog/odsr_pkg.sv
package odsr_pkg;

  // Command codes of the two scale registers.
  localparam logic [7:0]  ODSR_CODE_LOOP    = 8'h29;
  localparam logic [7:0]  ODSR_CODE_MONITOR = 8'h2a;

  // Fixed field layout of both words.
  localparam logic [4:0]  ODSR_EXPONENT     = 5'h1d;
  localparam int          ODSR_EXP_LSB      = 11;
  localparam int          ODSR_MANT_MSB     = 3;
  localparam logic [6:0]  ODSR_UNUSED_BITS  = 7'h00;

  // Mantissa values that matter to the hardware.
  localparam logic [3:0]  ODSR_MANT_EXTERNAL = 4'h8;
  localparam logic [3:0]  ODSR_MANT_RESET    = 4'h8;
  localparam logic [15:0] ODSR_READ_RESET    = 16'h0000;

  // Quantization thresholds: below 2, below 4, below 8.
  localparam logic [3:0]  ODSR_LIMIT_QUARTER = 4'h2;
  localparam logic [3:0]  ODSR_LIMIT_HALF    = 4'h4;
  localparam logic [3:0]  ODSR_LIMIT_UNITY   = 4'h8;

  // Applied divider gain codes.
  typedef enum logic [1:0] {
    ODSR_GAIN_EIGHTH  = 2'h0,
    ODSR_GAIN_QUARTER = 2'h1,
    ODSR_GAIN_HALF    = 2'h2,
    ODSR_GAIN_UNITY   = 2'h3
  } odsr_gain_type;

  // Canonical mantissa restored for a saved gain: 1, 2, 4 or 8.
  function automatic logic [3:0] odsr_canonical(input logic [1:0] gain);
    logic [3:0] mant;
    mant = 4'h1;
    case (gain)
      2'h0:    mant = 4'h1;
      2'h1:    mant = 4'h2;
      2'h2:    mant = 4'h4;
      default: mant = 4'h8;
    endcase
    return mant;
  endfunction

endpackage

//--- verilog/odsr_gain_quant.sv
`timescale 1ns/100ps
module odsr_gain_quant
  import odsr_pkg::*;
(
  input  wire logic [3:0]    i_mantissa,
  output odsr_gain_type      o_gain
);

  // Rounds any stored mantissa down onto a supported divider gain step; 0 and 1 both give eighth.
  always_comb begin
    if (i_mantissa < ODSR_LIMIT_QUARTER) begin
      o_gain = ODSR_GAIN_EIGHTH;
    end else if (i_mantissa < ODSR_LIMIT_HALF) begin
      o_gain = ODSR_GAIN_QUARTER;
    end else if (i_mantissa < ODSR_LIMIT_UNITY) begin
      o_gain = ODSR_GAIN_HALF;
    end else begin
      o_gain = ODSR_GAIN_UNITY;
    end
  end

endmodule

//--- verilog/odsr_scale_regs.sv
`timescale 1ns/100ps
module odsr_scale_regs
  import odsr_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_cmd_valid,
  input  wire logic          i_cmd_write,
  input  wire logic [7:0]    i_cmd_code,
  input  wire logic [15:0]   i_wr_data,
  input  wire logic          i_feedback_config_strap,
  input  wire logic          i_output_enabled,
  input  wire logic          i_strap_override_bit,
  input  wire logic          i_pin_load,
  input  wire logic [3:0]    i_voltage_select_pin_mantissa,
  input  wire logic          i_nvm_restore,
  input  wire logic [1:0]    i_nvm_loop_gain,
  input  wire logic [1:0]    i_nvm_monitor_gain,
  output logic [15:0]        o_rd_data,
  output logic               o_rd_valid,
  output logic               o_wr_ack,
  output logic               o_cmd_nack,
  output logic [1:0]         o_loop_divider_gain,
  output logic [1:0]         o_monitor_scale_gain
);

  // Stored mantissas; the monitor one keeps its own value while not in use, the loop one is forced to 8 under the strap.
  // Both reset to 8, unity gain, until pin detection or NVM loads them.
  logic [3:0]    loop_mantissa;
  logic [3:0]    monitor_mantissa;
  // Command decode of the presented word command.
  logic          hit_loop;
  logic          hit_monitor;
  logic          hit_mapped;
  logic          cmd_read;
  logic          cmd_write;
  // Write permission and the strobes that follow from it.
  logic          loop_write_ok;
  logic          monitor_write_ok;
  logic          loop_write;
  logic          monitor_write;
  logic          write_refused;
  // Load requests from pin detection and from NVM.
  logic          pin_load_take;
  logic          nvm_restore_take;
  // Read side and quantizer connections; entry 0 is the loop path, entry 1 the monitor path.
  logic [3:0]    monitor_view;
  logic [15:0]   read_word;
  logic [3:0]    quant_mantissa [2];
  odsr_gain_type quant_gain [2];

  // Command decode; only the two scale codes are mapped here.
  // Codes outside the pair are refused on reads and writes alike.
  assign hit_loop    = i_cmd_code == ODSR_CODE_LOOP;
  assign hit_monitor = i_cmd_code == ODSR_CODE_MONITOR;
  assign hit_mapped  = hit_loop || hit_monitor;
  assign cmd_read    = i_cmd_valid && !i_cmd_write;
  assign cmd_write   = i_cmd_valid && i_cmd_write;

  // The loop word sets the internal divider, so changing it under load would step
  // the output voltage; it is therefore writable only with the rail off.
  assign loop_write_ok    = !i_feedback_config_strap && !i_output_enabled;
  // The monitor word only scales readback; it is writable only while the external divider strap is set.
  assign monitor_write_ok = i_feedback_config_strap;

  // Accepted and refused write strobes.
  assign loop_write    = cmd_write && hit_loop && loop_write_ok;
  assign monitor_write = cmd_write && hit_monitor && monitor_write_ok;
  assign write_refused = cmd_write &&
                         ((hit_loop && !loop_write_ok) ||
                          (hit_monitor && !monitor_write_ok));

  // Pin detection feeds the monitor mantissa, and the loop one while the strap is clear, unless the override hands them to NVM.
  assign pin_load_take    = i_pin_load && !i_strap_override_bit;
  // An NVM restore only counts once the override bit selects NVM as the source.
  // It writes the canonical mantissa of the saved gain, not a raw value.
  assign nvm_restore_take = i_nvm_restore && i_strap_override_bit;

  // Monitor word mirrors the loop word while the internal divider is used; the
  // stored monitor value is kept underneath for when the strap changes.
  assign monitor_view = i_feedback_config_strap ? monitor_mantissa : loop_mantissa;

  // Read word of the addressed register; fixed exponent and zero filler around the mantissa.
  // The default branch keeps the word defined for codes that are never read.
  always_comb begin
    read_word = ODSR_READ_RESET;
    case (i_cmd_code)
      ODSR_CODE_LOOP: begin
        read_word = {ODSR_EXPONENT, ODSR_UNUSED_BITS, loop_mantissa};
      end
      ODSR_CODE_MONITOR: begin
        read_word = {ODSR_EXPONENT, ODSR_UNUSED_BITS, monitor_view};
      end
      default: begin
        read_word = ODSR_READ_RESET;
      end
    endcase
  end

  // Loop mantissa: strap force first, then pin or NVM load, then a permitted host write.
  // The strap force wins even over a load, so an external divider always sees 8.
  // A refused write falls through every branch and leaves the value alone.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      loop_mantissa <= ODSR_MANT_RESET;
    end else if (i_feedback_config_strap) begin
      loop_mantissa <= ODSR_MANT_EXTERNAL;
    end else if (pin_load_take) begin
      loop_mantissa <= i_voltage_select_pin_mantissa;
    end else if (nvm_restore_take) begin
      loop_mantissa <= odsr_canonical(i_nvm_loop_gain);
    end else if (loop_write) begin
      loop_mantissa <= i_wr_data[ODSR_MANT_MSB:0];
    end
  end

  // Monitor mantissa: pin or NVM load, then a permitted host write.
  // No strap force here: an external divider is exactly when the host owns it.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      monitor_mantissa <= ODSR_MANT_RESET;
    end else if (pin_load_take) begin
      monitor_mantissa <= i_voltage_select_pin_mantissa;
    end else if (nvm_restore_take) begin
      monitor_mantissa <= odsr_canonical(i_nvm_monitor_gain);
    end else if (monitor_write) begin
      monitor_mantissa <= i_wr_data[ODSR_MANT_MSB:0];
    end
  end

  // Read strobe pulses for one cycle, one cycle after the request.
  // Unmapped reads are answered by the refusal strobe instead.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= cmd_read && hit_mapped;
    end
  end

  // Read data is captured with the strobe and holds until the next read of a scale code.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= ODSR_READ_RESET;
    end else if (cmd_read && hit_mapped) begin
      o_rd_data <= read_word;
    end
  end

  // Write acknowledge, one cycle after an accepted write.
  // Back-to-back commands each get their own strobe; nothing is queued.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wr_ack <= 1'b0;
    end else begin
      o_wr_ack <= loop_write || monitor_write;
    end
  end

  // Refusal, one cycle after an unmapped code or a write that is not permitted.
  // A refusal leaves storage alone; the host sees it as a one-cycle pulse.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_cmd_nack <= 1'b0;
    end else begin
      o_cmd_nack <= (i_cmd_valid && !hit_mapped) || write_refused;
    end
  end

  // Quantizer inputs: the loop mantissa and the mantissa the monitor path uses.
  // Entry 1 sees the mirrored loop value while the internal divider is used.
  assign quant_mantissa[0] = loop_mantissa;
  assign quant_mantissa[1] = monitor_view;

  // One quantizer per scale register maps any stored mantissa onto its gain step.
  // The thresholds live in the quantizer so both paths share one mapping.
  generate
    for (genvar entry = 0; entry < 2; entry++) begin : gen_quant
      odsr_gain_quant odsr_gain_quant_inst (
        .i_mantissa (quant_mantissa[entry]),
        .o_gain     (quant_gain[entry])
      );
    end
  endgenerate

  // Applied loop gain, registered so the divider select never glitches on a write.
  // After reset it shows unity, matching the reset mantissa of 8.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_loop_divider_gain <= ODSR_GAIN_UNITY;
    end else begin
      o_loop_divider_gain <= quant_gain[0];
    end
  end

  // Applied readback gain; a permitted monitor write reaches it two edges later.
  // While the internal divider is in use it follows the loop gain exactly.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_monitor_scale_gain <= ODSR_GAIN_UNITY;
    end else begin
      o_monitor_scale_gain <= quant_gain[1];
    end
  end

endmodule

//--- verif/odsr_scale_regs_assertions.sv
`timescale 1ns/100ps
module odsr_checker
  import odsr_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_write,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_feedback_config_strap,
  input wire logic        i_output_enabled,
  input wire logic [15:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        o_wr_ack,
  input wire logic        o_cmd_nack,
  input wire logic [1:0]  o_loop_divider_gain,
  input wire logic [1:0]  o_monitor_scale_gain
);
  // Checks run on the system clock and rest during reset.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Command shapes, and a settled stretch on the internal divider.
  sequence s_wr(c); i_cmd_valid && i_cmd_write && i_cmd_code == c; endsequence
  sequence s_rd; i_cmd_valid && !i_cmd_write && i_cmd_code inside {8'h29, 8'h2a}; endsequence
  sequence s_int; (!i_feedback_config_strap && $stable(o_loop_divider_gain)) [*3]; endsequence
  a_fixed_bits: assert property (o_rd_valid |-> o_rd_data[15:4] == 12'he80)
    else $error("fixed bits wrong");
  a_read_answer: assert property (s_rd |=> o_rd_valid)
    else $error("read not answered");
  a_loop_locked: assert property (s_wr(8'h29) ##0 i_output_enabled |=> o_cmd_nack)
    else $error("loop write while enabled");
  a_loop_strap: assert property (s_wr(8'h29) ##0 i_feedback_config_strap |=> !o_wr_ack)
    else $error("loop write with strap");
  a_mon_refused: assert property (s_wr(8'h2a) ##0 !i_feedback_config_strap |=> o_cmd_nack)
    else $error("monitor write on internal");
  a_mon_accept: assert property (s_wr(8'h2a) ##0 i_feedback_config_strap |=> o_wr_ack)
    else $error("monitor write refused");
  a_strap_force: assert property (i_feedback_config_strap [*4] |-> o_loop_divider_gain == 2'h3)
    else $error("strap not forcing unity");
  a_mon_mirror: assert property (s_int |-> o_monitor_scale_gain == o_loop_divider_gain)
    else $error("monitor not mirroring");
endmodule
bind odsr_scale_regs odsr_checker odsr_checker_inst (.*);

//--- verif/odsr_host_model.sv
`timescale 1ns/100ps
module odsr_host_model (
  input  wire logic        i_sys_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  input  wire logic        i_wr_ack,
  input  wire logic        i_cmd_nack,
  output logic             o_cmd_valid = 1'b0,
  output logic             o_cmd_write = 1'b0,
  output logic [7:0]       o_cmd_code  = 8'h00,
  output logic [15:0]      o_wr_data   = 16'h0000
);
  // One word command; code and data are inverted once released so stale values never match.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [1:0] r, output logic [15:0] q);
    r = 2'h3;
    @(posedge i_sys_clk) #1;
    {o_cmd_valid, o_cmd_write, o_cmd_code, o_wr_data} = {1'b1, w, c, d};
    @(posedge i_sys_clk) #1;
    {o_cmd_valid, o_cmd_code, o_wr_data} = {1'b0, ~c, ~d};
    for (int n = 0; n < 3 && r == 2'h3; n++) begin
      if (i_rd_valid === 1'b1) r = 2'h0;
      else if (i_wr_ack === 1'b1) r = 2'h1;
      else if (i_cmd_nack === 1'b1) r = 2'h2;
      else @(posedge i_sys_clk) #1;
    end
    q = i_rd_data;
  endtask
endmodule

//--- verif/test_output_divider_scale_regs.sv
`timescale 1ns/100ps
module test_output_divider_scale_regs;
  import odsr_pkg::*;
  logic        clk, rst, strap, oe, ovr, pl, nr, valid, wr, rv, ack, nack;
  logic [3:0]  pm;
  logic [1:0]  nlg, nmg, lg, mg;
  logic [7:0]  code;
  logic [15:0] wd, rd;
  int          num_errors = 0;
  int          total_checks = 0;
  odsr_host_model odsr_host_model_inst (.i_sys_clk(clk), .i_rd_data(rd), .i_rd_valid(rv),
    .i_wr_ack(ack), .i_cmd_nack(nack), .o_cmd_valid(valid), .o_cmd_write(wr),
    .o_cmd_code(code), .o_wr_data(wd));
  odsr_scale_regs odsr_scale_regs_inst (.i_sys_clk(clk), .i_reset(rst), .i_cmd_valid(valid),
    .i_cmd_write(wr), .i_cmd_code(code), .i_wr_data(wd), .i_feedback_config_strap(strap),
    .i_output_enabled(oe), .i_strap_override_bit(ovr), .i_pin_load(pl),
    .i_voltage_select_pin_mantissa(pm), .i_nvm_restore(nr), .i_nvm_loop_gain(nlg),
    .i_nvm_monitor_gain(nmg), .o_rd_data(rd), .o_rd_valid(rv), .o_wr_ack(ack),
    .o_cmd_nack(nack), .o_loop_divider_gain(lg), .o_monitor_scale_gain(mg));
  // Compares one value and counts the outcome.
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One command with junk in bits 15:4; answer kind 0 read, 1 ack, 2 nack.
  task automatic cmd(input logic w, input logic [7:0] c, input logic [3:0] d,
                     input logic [1:0] er, input logic [3:0] em);
    logic [1:0] r;
    logic [15:0] q;
    odsr_host_model_inst.xfer(w, c, {12'hfff, d}, r, q);
    chk("answer", {14'h0, er}, {14'h0, r});
    if (r === 2'h3) report_and_stop();
    if (er == 2'h0) chk("read word", 16'he800 | em, q);
  endtask
  // Gains after their one-cycle lag behind the mantissa.
  task automatic gains(input logic [1:0] el, input logic [1:0] em);
    repeat (2) @(posedge clk);
    #1 chk("gains", {12'h0, el, em}, {12'h0, lg, mg});
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #1 s = 1'b1;
    @(posedge clk) #1 s = 1'b0;
  endtask
  task automatic t_reset;
    cmd(0, ODSR_CODE_LOOP, 0, 0, 8);
    cmd(0, ODSR_CODE_MONITOR, 0, 0, 8);
    cmd(1, 8'h2b, 1, 2, 0);
  endtask
  task automatic t_quant;
    logic [1:0] g;
    for (int m = 0; m < 16; m++) begin
      g = m < 2 ? 2'h0 : m < 4 ? 2'h1 : m < 8 ? 2'h2 : 2'h3;
      cmd(1, ODSR_CODE_LOOP, m[3:0], 1, 0);
      cmd(0, ODSR_CODE_LOOP, 0, 0, m[3:0]);
      cmd(0, ODSR_CODE_MONITOR, 0, 0, m[3:0]);
      gains(g, g);
    end
  endtask
  task automatic t_refuse;
    cmd(1, ODSR_CODE_MONITOR, 3, 2, 0);
    oe = 1'b1;
    cmd(1, ODSR_CODE_LOOP, 5, 2, 0);
    cmd(0, ODSR_CODE_LOOP, 0, 0, 15);
  endtask
  task automatic t_external;
    strap = 1'b1;
    cmd(0, ODSR_CODE_LOOP, 0, 0, 8);
    cmd(1, ODSR_CODE_LOOP, 2, 2, 0);
    cmd(1, ODSR_CODE_MONITOR, 3, 1, 0);
    cmd(0, ODSR_CODE_MONITOR, 0, 0, 3);
    gains(3, 1);
    {strap, oe, pm} = {2'b00, 4'h6};
  endtask
  task automatic t_load;
    pulse(pl);
    cmd(0, ODSR_CODE_LOOP, 0, 0, 6);
    {nlg, nmg} = {2'h1, 2'h2};
    pulse(nr);
    cmd(0, ODSR_CODE_LOOP, 0, 0, 6);
    ovr = 1'b1;
    pulse(nr);
    cmd(0, ODSR_CODE_LOOP, 0, 0, 2);
    pulse(pl);
    cmd(0, ODSR_CODE_LOOP, 0, 0, 2);
    strap = 1'b1;
    cmd(0, ODSR_CODE_MONITOR, 0, 0, 4);
    gains(3, 2);
  endtask
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Reset, then the scenarios in order.
  initial begin
    {rst, strap, oe, ovr, pl, nr, pm, nlg, nmg} = {6'b100000, 8'h00};
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    t_reset();
    t_quant();
    t_refuse();
    t_external();
    t_load();
    report_and_stop();
  end
endmodule
